// >>> shared/rcc_consts.svh
/*
  Constants of the recording-control block: register addresses, field positions,
  reset value and counts. Assumes inclusion by every design file of the block.
*/
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH
// ==========================================
// Register addresses and reset value
`define RCC_ADDR_LO 7'h1A
`define RCC_ADDR_HI 7'h1B
`define RCC_RESET 16'h1102
`define RCC_WRITE_MASK 16'hBFFF
`define RCC_WRITE_BIT 15
// ==========================================
// Field positions
`define RCC_F_MODE 0
`define RCC_F_STORE 2
`define RCC_F_MAG 4
`define RCC_F_VEL 5
`define RCC_F_STAT 6
`define RCC_F_PDN 7
`define RCC_F_RATE 8
`define RCC_F_WIN 12
`define RCC_F_TMO 15
// ==========================================
// Field codes
`define RCC_MODE_MSPEC 2'h0
`define RCC_MODE_ASPEC 2'h1
`define RCC_MODE_MTC 2'h2
`define RCC_MODE_STREAM 2'h3
`define RCC_STORE_NONE 2'h0
`define RCC_STORE_ALARM 2'h1
`define RCC_STORE_ALL 2'h2
// ==========================================
// Counts and rates
`define RCC_TMO_PERIODS 3'h5
`define RCC_FRAME_LAST 4'hF
`define RCC_BASE_RATE_SPS 220000
`endif

// >>> shared/rcc_pkg.sv
/*
  Types of the recording-control block.
  Assumes nothing of its surroundings.
*/
package rcc_pkg;
  // ==========================================
  // Sequencing states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CAPTURE,
    ST_SLEEP,
    ST_STREAM
  } rcc_state_type;
endpackage : rcc_pkg

// >>> design/rcc_spi_slave.sv
/*
  Serial slave: synchronises chip select, serial clock and data in, gathers
  16-bit frames, shifts a reply word out. Assumes serial clock idles high.
*/
`timescale 1ns/1ps
`include "rcc_consts.svh"
module rcc_spi_slave (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic [15:0] tx_word,
  output logic dout,
  output logic frame_valid,
  output logic [15:0] frame_word,
  output logic cs_fall,
  output logic sclk_rise
);
  logic [2:0] cs_s;
  logic [2:0] sck_s;
  logic [1:0] din_s;
  logic [3:0] bit_cnt_r;
  logic [15:0] rx_sh_r;
  logic [15:0] tx_sh_r;
  logic sclk_fall;

  // ==========================================
  // Synchronisers; stage 0 feeds stage 1 only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cs_s <= 3'h7;
      sck_s <= 3'h7;
      din_s <= 2'h0;
    end else begin
      cs_s <= {cs_s[1:0], cs_n};
      sck_s <= {sck_s[1:0], sclk};
      din_s <= {din_s[0], din};
    end
  end

  assign cs_fall = !cs_s[1] && cs_s[2];
  assign sclk_rise = sck_s[1] && !sck_s[2];
  assign sclk_fall = !sck_s[1] && sck_s[2] && !cs_s[1];

  // ==========================================
  // Receive side
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bit_cnt_r <= 4'h0;
      rx_sh_r <= 16'h0000;
      frame_valid <= 1'b0;
      frame_word <= 16'h0000;
    end else begin
      frame_valid <= 1'b0;
      if (cs_s[1]) begin
        bit_cnt_r <= 4'h0;
      end else if (sclk_rise) begin
        rx_sh_r <= {rx_sh_r[14:0], din_s[1]};
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (bit_cnt_r == `RCC_FRAME_LAST) begin
          frame_valid <= 1'b1;
          frame_word <= {rx_sh_r[14:0], din_s[1]};
        end
      end
    end
  end

  // ==========================================
  // Transmit side; bit 15 stands from select and is reloaded at the first fall, so mode 3 loses no bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_sh_r <= 16'h0000;
      dout <= 1'b0;
    end else if (cs_fall) begin
      dout <= tx_word[15];
      tx_sh_r <= tx_word;
    end else if (sclk_fall) begin
      dout <= tx_sh_r[15];
      tx_sh_r <= {tx_sh_r[14:0], 1'b0};
    end
  end
endmodule : rcc_spi_slave

// >>> design/rcc_rate_seq.sv
/*
  Sample-rate selector rotation across capture events.
  Assumes advance is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`include "rcc_consts.svh"
module rcc_rate_seq (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] enable_mask,
  input wire logic advance,
  input wire logic [15:0] exponents,
  output logic [1:0] rate_sel,
  output logic [3:0] rate_exponent
);
  // Next enabled selector after cur, ascending with wrap
  function automatic logic [1:0] rcc_next_sel(input logic [3:0] m, input logic [1:0] cur);
    logic [1:0] idx;
    rcc_next_sel = cur;
    for (int i = 4; i >= 1; i--) begin
      idx = cur + 2'(i);
      if (m[idx]) begin
        rcc_next_sel = idx;
      end
    end
  endfunction : rcc_next_sel

  // ==========================================
  // Selector; reset at 3 so the first event takes the lowest set selector
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rate_sel <= 2'h3;
    end else if (advance) begin
      rate_sel <= rcc_next_sel(enable_mask, rate_sel);
    end
  end

  // Rate = base rate over two to this exponent
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rate_exponent <= 4'h0;
    end else begin
      rate_exponent <= exponents[rate_sel * 4 +: 4];
    end
  end

  // ==========================================
  // Checks
  property p_single_rate;
    @(posedge clk) disable iff (!nrst)
    (advance && $countones(enable_mask) == 1)
      |=> (enable_mask[rate_sel] && $stable(enable_mask) || !$stable(enable_mask));
  endproperty
  a_single_rate: assert property (p_single_rate) else $error("single selector not held");
  property p_two_alternate;
    @(posedge clk) disable iff (!nrst)
    (advance && $countones(enable_mask) == 2 && enable_mask[rate_sel]) |=> (rate_sel != $past(rate_sel));
  endproperty
  a_two_alternate: assert property (p_two_alternate) else $error("two selectors did not alternate");
  property p_four_cycle;
    @(posedge clk) disable iff (!nrst)
    (advance && enable_mask == 4'hF) |=> (rate_sel == $past(rate_sel) + 2'h1);
  endproperty
  a_four_cycle: assert property (p_four_cycle) else $error("four selectors out of order");
  property p_rate_exp;
    @(posedge clk) disable iff (!nrst)
    ($past(nrst) && $stable(rate_sel) && $stable(exponents)) |-> (rate_exponent == exponents[rate_sel * 4 +: 4]);
  endproperty
  a_rate_exp: assert property (p_rate_exp) else $error("rate exponent mismatch");
endmodule : rcc_rate_seq

// >>> design/rcc_top.sv
/*
  Recording-control register and capture, sleep and streaming sequencing.
  Assumes the host reaches the register over the serial port; trigger, done,
  alarm and data-ready inputs come from logic on clk.
*/
`timescale 1ns/1ps
`include "rcc_consts.svh"
// Function
// - Mode field picks manual spectral, automatic spectral, time capture or streaming.
// - Storage code 00 writes no record; result stays in SRAM; 11 reserved.
// - Storage code 01 stores a record only when an alarm is exceeded.
// - Storage code 10 stores a record after every capture event.
// - Magnitude bit makes z buffer hold three-axis magnitude outside streaming.
// - Magnitude bit clear keeps every axis processed separately.
// - Velocity bit selects integrated velocity, else acceleration, in buffers.
// - Statistics bit enables statistics in manual time capture mode.
// - Power-down bit sends device to sleep after capture, else stays awake.
// - Automatic spectral mode wakes itself for the next capture.
// - Timeout bit halts streaming after five data-ready periods without clock.
// - Without timeout, the streaming pin starts and stops streaming; leaving streaming mode also stops it.
// - Window field: 00 rectangular, 01 Hanning, 10 flat top.
// - One selector set: every capture uses that rate.
// - Two selectors set: captures alternate between both rates.
// - Four selectors set: rates cycle 0, 1, 2, 3, repeat.
// - Selector rate is base rate over two to its exponent field.
module rcc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  input wire logic streaming_pin,
  input wire logic capture_request,
  input wire logic auto_timer_tick,
  input wire logic capture_done,
  input wire logic alarm_exceeded,
  input wire logic data_ready,
  input wire logic [15:0] decimation_exponents,
  output logic [1:0] recording_mode,
  output logic capture_start,
  output logic store_record,
  output logic sram_hold,
  output logic z_is_magnitude,
  output logic velocity_select,
  output logic statistics_enable,
  output logic [1:0] window_select,
  output logic sleeping,
  output logic streaming_active,
  output logic stream_timed_out,
  output logic [1:0] rate_select,
  output logic [3:0] rate_exponent
);
  logic [15:0] recording_control_r;
  logic [6:0] rd_addr_r;
  logic [15:0] tx_word;
  logic frame_valid;
  logic [15:0] frame_word;
  logic cs_fall;
  logic sclk_rise;
  logic [1:0] pin_s;
  rcc_pkg::rcc_state_type state_r;
  rcc_pkg::rcc_state_type state_nxt;
  logic [2:0] tmo_cnt_r;
  logic halt_r;
  logic timeout_hit;
  logic capture_go;
  logic store_now;
  logic [1:0] mode;
  logic [1:0] policy;
  logic spectral_or_capture;

  function automatic logic rcc_hit(input logic [6:0] a);
    rcc_hit = (a == `RCC_ADDR_LO) || (a == `RCC_ADDR_HI);
  endfunction : rcc_hit

  // ==========================================
  // Serial port
  rcc_spi_slave u_spi (
    .clk(clk),
    .nrst(nrst),
    .cs_n(cs_n),
    .sclk(sclk),
    .din(din),
    .tx_word(tx_word),
    .dout(dout),
    .frame_valid(frame_valid),
    .frame_word(frame_word),
    .cs_fall(cs_fall),
    .sclk_rise(sclk_rise)
  );

  // Reply to the read of the previous frame
  assign tx_word = rcc_hit(rd_addr_r) ? recording_control_r : 16'h0000;

  // ==========================================
  // Register writes, one byte per frame
  always_ff @(posedge clk) begin
    if (!nrst) begin
      recording_control_r <= `RCC_RESET;
    end else if (frame_valid && frame_word[`RCC_WRITE_BIT]) begin
      if (frame_word[14:8] == `RCC_ADDR_LO) begin
        recording_control_r[7:0] <= frame_word[7:0];
      end else if (frame_word[14:8] == `RCC_ADDR_HI) begin
        recording_control_r[15:8] <= frame_word[7:0] & 8'(`RCC_WRITE_MASK >> 8);
      end
    end
  end

  // Read address; a write frame clears the pending reply
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_addr_r <= 7'h00;
    end else if (frame_valid) begin
      rd_addr_r <= frame_word[`RCC_WRITE_BIT] ? 7'h00 : frame_word[14:8];
    end
  end

  // ==========================================
  // Field decode
  assign mode = recording_control_r[`RCC_F_MODE +: 2];
  assign policy = recording_control_r[`RCC_F_STORE +: 2];
  assign spectral_or_capture = (mode != `RCC_MODE_STREAM);
  // Reserved storage code behaves as no storage
  assign store_now = capture_done && (state_r == rcc_pkg::ST_CAPTURE)
    && ((policy == `RCC_STORE_ALL) || (policy == `RCC_STORE_ALARM && alarm_exceeded));

  // Streaming pin comes from outside
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_s <= 2'h0;
    end else begin
      pin_s <= {pin_s[0], streaming_pin};
    end
  end

  // ==========================================
  // Sequencing
  assign capture_go = ((state_r == rcc_pkg::ST_IDLE) && spectral_or_capture
    && ((mode == `RCC_MODE_ASPEC) ? auto_timer_tick : capture_request))
    || ((state_r == rcc_pkg::ST_SLEEP) && mode == `RCC_MODE_ASPEC && auto_timer_tick);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rcc_pkg::ST_IDLE: begin
        if (capture_go) begin
          state_nxt = rcc_pkg::ST_CAPTURE;
        end else if (mode == `RCC_MODE_STREAM && pin_s[1] && !halt_r) begin
          state_nxt = rcc_pkg::ST_STREAM;
        end
      end
      rcc_pkg::ST_CAPTURE: begin
        if (capture_done) begin
          state_nxt = recording_control_r[`RCC_F_PDN] ? rcc_pkg::ST_SLEEP : rcc_pkg::ST_IDLE;
        end
      end
      rcc_pkg::ST_SLEEP: begin
        if (capture_go) begin
          state_nxt = rcc_pkg::ST_CAPTURE;
        end else if (cs_fall) begin
          state_nxt = rcc_pkg::ST_IDLE;
        end
      end
      rcc_pkg::ST_STREAM: begin
        if (!pin_s[1] || timeout_hit || mode != `RCC_MODE_STREAM) begin
          state_nxt = rcc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = rcc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= rcc_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================
  // Streaming timeout; a clock edge in the same cycle wins over data ready
  assign timeout_hit = recording_control_r[`RCC_F_TMO] && data_ready && !sclk_rise
    && (tmo_cnt_r == `RCC_TMO_PERIODS - 3'h1);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tmo_cnt_r <= 3'h0;
    end else if (state_r != rcc_pkg::ST_STREAM || sclk_rise) begin
      tmo_cnt_r <= 3'h0;
    end else if (data_ready && tmo_cnt_r != `RCC_TMO_PERIODS) begin
      tmo_cnt_r <= tmo_cnt_r + 3'h1;
    end
  end

  // Halt holds until the pin drops, so a stalled host cannot restart streaming
  always_ff @(posedge clk) begin
    if (!nrst) begin
      halt_r <= 1'b0;
    end else if (state_r == rcc_pkg::ST_STREAM && timeout_hit) begin
      halt_r <= 1'b1;
    end else if (!pin_s[1]) begin
      halt_r <= 1'b0;
    end
  end

  // ==========================================
  // Rate rotation
  rcc_rate_seq u_rate (
    .clk(clk),
    .nrst(nrst),
    .enable_mask(recording_control_r[`RCC_F_RATE +: 4]),
    .advance(capture_go),
    .exponents(decimation_exponents),
    .rate_sel(rate_select),
    .rate_exponent(rate_exponent)
  );

  // ==========================================
  // Registered outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      capture_start <= 1'b0;
      store_record <= 1'b0;
    end else begin
      capture_start <= capture_go;
      store_record <= store_now;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      recording_mode <= `RCC_MODE_MSPEC;
      sram_hold <= 1'b0;
      z_is_magnitude <= 1'b0;
      velocity_select <= 1'b0;
      statistics_enable <= 1'b0;
      window_select <= 2'h0;
      sleeping <= 1'b0;
      streaming_active <= 1'b0;
      stream_timed_out <= 1'b0;
    end else begin
      recording_mode <= mode;
      sram_hold <= (policy == `RCC_STORE_NONE) || (policy == 2'h3);
      z_is_magnitude <= recording_control_r[`RCC_F_MAG] && spectral_or_capture;
      velocity_select <= recording_control_r[`RCC_F_VEL];
      statistics_enable <= recording_control_r[`RCC_F_STAT] && mode == `RCC_MODE_MTC;
      window_select <= recording_control_r[`RCC_F_WIN +: 2];
      sleeping <= (state_nxt == rcc_pkg::ST_SLEEP);
      streaming_active <= (state_nxt == rcc_pkg::ST_STREAM);
      stream_timed_out <= halt_r;
    end
  end

  // ==========================================
  // Checks
  property p_mode_out;
    @(posedge clk) disable iff (!nrst)
    ($past(nrst) && $stable(mode)) |-> (recording_mode == mode);
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("mode output mismatch");
  property p_no_store;
    @(posedge clk) disable iff (!nrst)
    (policy == `RCC_STORE_NONE && $stable(policy)) |=> !store_record;
  endproperty
  a_no_store: assert property (p_no_store) else $error("record stored with storage off");
  property p_alarm_store;
    @(posedge clk) disable iff (!nrst)
    (state_r == rcc_pkg::ST_CAPTURE && capture_done && policy == `RCC_STORE_ALARM)
      |=> (store_record == $past(alarm_exceeded));
  endproperty
  a_alarm_store: assert property (p_alarm_store) else $error("alarm storage wrong");
  property p_all_store;
    @(posedge clk) disable iff (!nrst)
    (state_r == rcc_pkg::ST_CAPTURE && capture_done && policy == `RCC_STORE_ALL) |=> store_record ##1 !store_record;
  endproperty
  a_all_store: assert property (p_all_store) else $error("record not stored");
  property p_magnitude;
    @(posedge clk) disable iff (!nrst)
    ($past(nrst) && $stable(recording_control_r))
      |-> (z_is_magnitude == (recording_control_r[`RCC_F_MAG] && mode != `RCC_MODE_STREAM));
  endproperty
  a_magnitude: assert property (p_magnitude) else $error("magnitude select wrong");
  property p_velocity;
    @(posedge clk) disable iff (!nrst)
    ($past(nrst) && $stable(recording_control_r)) |-> (velocity_select == recording_control_r[`RCC_F_VEL]);
  endproperty
  a_velocity: assert property (p_velocity) else $error("velocity select wrong");
  property p_stats;
    @(posedge clk) disable iff (!nrst)
    ($past(nrst) && $stable(recording_control_r))
      |-> (statistics_enable == (recording_control_r[`RCC_F_STAT] && mode == `RCC_MODE_MTC));
  endproperty
  a_stats: assert property (p_stats) else $error("statistics enable wrong");
  property p_power_down;
    @(posedge clk) disable iff (!nrst)
    (state_r == rcc_pkg::ST_CAPTURE && capture_done) |=> (sleeping == $past(recording_control_r[`RCC_F_PDN]));
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down decision wrong");
  property p_self_wake;
    @(posedge clk) disable iff (!nrst)
    (state_r == rcc_pkg::ST_SLEEP && mode == `RCC_MODE_ASPEC && auto_timer_tick) |=> capture_start && !sleeping;
  endproperty
  a_self_wake: assert property (p_self_wake) else $error("no self wake");
  property p_timeout;
    @(posedge clk) disable iff (!nrst)
    (state_r == rcc_pkg::ST_STREAM && timeout_hit) |=> !streaming_active ##1 stream_timed_out;
  endproperty
  a_timeout: assert property (p_timeout) else $error("streaming not halted");
  property p_pin_only;
    @(posedge clk) disable iff (!nrst)
    (state_r == rcc_pkg::ST_STREAM && !recording_control_r[`RCC_F_TMO] && pin_s[1] && mode == `RCC_MODE_STREAM)
      |=> (state_r == rcc_pkg::ST_STREAM);
  endproperty
  a_pin_only: assert property (p_pin_only) else $error("streaming stopped without pin");
  property p_window;
    @(posedge clk) disable iff (!nrst)
    ($past(nrst) && $stable(recording_control_r)) |-> (window_select == recording_control_r[`RCC_F_WIN +: 2]);
  endproperty
  a_window: assert property (p_window) else $error("window select wrong");
  property p_sram_hold;
    @(posedge clk) disable iff (!nrst)
    ($past(nrst) && $stable(policy)) |-> (sram_hold == (policy == `RCC_STORE_NONE || policy == 2'h3));
  endproperty
  a_sram_hold: assert property (p_sram_hold) else $error("sram hold wrong");
  property p_start_pulse;
    @(posedge clk) disable iff (!nrst)
    capture_start |=> !capture_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("capture start longer than one cycle");
  property p_stream_start;
    @(posedge clk) disable iff (!nrst)
    (state_r == rcc_pkg::ST_IDLE && mode == `RCC_MODE_STREAM && pin_s[1] && !halt_r) |=> streaming_active;
  endproperty
  a_stream_start: assert property (p_stream_start) else $error("streaming pin did not start streaming");
  property p_halt_blocks;
    @(posedge clk) disable iff (!nrst)
    (halt_r && pin_s[1]) |=> !streaming_active;
  endproperty
  a_halt_blocks: assert property (p_halt_blocks) else $error("streaming restarted after timeout");
  property p_sleep_holds;
    @(posedge clk) disable iff (!nrst)
    (state_r == rcc_pkg::ST_SLEEP && !cs_fall && !capture_go) |=> sleeping;
  endproperty
  a_sleep_holds: assert property (p_sleep_holds) else $error("sleep left without wake");
endmodule : rcc_top

// >>> sim/rcc_host_model.sv
/*
  Host model: serial master in mode 3, 16-bit frames, MSB first.
  Assumes clk paces its edges; the slave synchronises every pin.
*/
`timescale 1ns/1ps
module rcc_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  // ==========================================
  // Idle pins
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b1;
  end

  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask : pause

  // ==========================================
  // Frames
  // Half period of 4 clk gives the 320 ns serial clock
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    pause(1);
    cs_n = 1'b0;
    for (i = 15; i >= 0; i--) begin
      pause(4);
      sclk = 1'b0;
      din = tx[i];
      pause(4);
      rx[i] = dout;
      sclk = 1'b1;
    end
    pause(4);
    cs_n = 1'b1;
    din = ~din; // No stale bit once released
    pause(4);
  endtask : xfer

  // Bare select toggle, no serial clocks
  task automatic wake();
    pause(1);
    cs_n = 1'b0;
    pause(4);
    cs_n = 1'b1;
    pause(4);
  endtask : wake
endmodule : rcc_host_model

// >>> sim/recording_control_config_tb_top.sv
/*
  Self-checking bench of the recording-control block.
  Assumes rcc_top and the host model; inputs change at falling clk edges.
*/
`timescale 1ns/1ps
`include "rcc_consts.svh"
module recording_control_config_tb_top;
  logic clk, nrst, cs_n, sclk, din, dout, streaming_pin, capture_request, auto_timer_tick;
  logic capture_done, alarm_exceeded, data_ready, capture_start, store_record, sram_hold;
  logic z_is_magnitude, velocity_select, statistics_enable, sleeping, streaming_active;
  logic stream_timed_out;
  logic [15:0] decimation_exponents;
  logic [1:0] recording_mode, window_select, rate_select;
  logic [3:0] rate_exponent;
  int n_fail, checks_done;

  rcc_top i_dut (.clk, .nrst, .cs_n, .sclk, .din, .dout, .streaming_pin, .capture_request,
    .auto_timer_tick, .capture_done, .alarm_exceeded, .data_ready, .decimation_exponents,
    .recording_mode, .capture_start, .store_record, .sram_hold, .z_is_magnitude,
    .velocity_select, .statistics_enable, .window_select, .sleeping, .streaming_active,
    .stream_timed_out, .rate_select, .rate_exponent);
  rcc_host_model i_host (.clk, .cs_n, .sclk, .din, .dout);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic do_reset();
    @(negedge clk);
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
  endtask : do_reset

  task automatic wr(input logic [15:0] v);
    logic [15:0] rx;
    i_host.xfer({1'b1, `RCC_ADDR_LO, v[7:0]}, rx);
    i_host.xfer({1'b1, `RCC_ADDR_HI, v[15:8]}, rx);
    repeat (3) @(negedge clk);
  endtask : wr

  // Reply arrives in the frame after the request
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    logic [15:0] rx;
    i_host.xfer({1'b0, a, 8'h00}, rx);
    i_host.xfer(16'h0000, v);
  endtask : rd

  // One-cycle pulse on s, then watch o for four cycles
  task automatic fire(ref logic s, ref logic o, output logic hit);
    int j;
    hit = 1'b0;
    s = 1'b1;
    for (j = 0; j < 4; j++) begin
      @(negedge clk);
      if (j == 0) s = 1'b0;
      if (o === 1'b1) hit = 1'b1;
    end
  endtask : fire

  function automatic logic [1:0] next_sel(input logic [3:0] m, input logic [1:0] c);
    logic [1:0] s;
    int k;
    s = c;
    for (k = 0; k < 4; k++) begin
      s = s + 2'h1;
      if (m[s]) return s;
    end
    return c;
  endfunction : next_sel

  task automatic cap_set(input logic [3:0] m, input logic [1:0] st);
    logic [1:0] sel;
    logic hit;
    int i;
    do_reset();
    decimation_exponents = 16'($urandom);
    wr({4'h0, m, 4'h0, st, 2'h0});
    sel = 2'h3;
    for (i = 0; i < 5; i++) begin
      sel = next_sel(m, sel);
      fire(capture_request, capture_start, hit);
      chk(hit, 1'b1);
      chk(rate_select, sel);
      chk(rate_exponent, decimation_exponents[4*sel+:4]);
      alarm_exceeded = 1'($urandom);
      fire(capture_done, store_record, hit);
      chk(hit, st == 2'h2 || (st == 2'h1 && alarm_exceeded));
      chk(sleeping, 1'b0);
    end
    $display("test rates mask %h done", m);
  endtask : cap_set

  initial begin
    #2_000_000;
    n_fail++;
    $display("run timed out");
    end_sim();
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [15:0] v, r;
    logic [3:0] masks [5];
    logic [1:0] stores [5];
    logic hit;
    int k;
    masks = '{4'h4, 4'h9, 4'hF, 4'hB, 4'h2};
    stores = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
    {nrst, streaming_pin, capture_request, auto_timer_tick} = 4'h0;
    {capture_done, alarm_exceeded, data_ready} = 3'h0;
    decimation_exponents = 16'h0000;
    n_fail = 0;
    checks_done = 0;
    void'($urandom(66856));
    do_reset();
    rd(`RCC_ADDR_LO, r);
    chk(r, `RCC_RESET);
    chk(window_select, 2'h1);
    i_host.xfer(16'h9CFF, r);
    rd(7'h1C, r);
    chk(r, 16'h0000);
    rd(`RCC_ADDR_HI, r);
    chk(r, `RCC_RESET);
    $display("test reset done");
    for (k = 0; k < 8; k++) begin
      v = 16'($urandom) & 16'hFF7F;
      if (k < 4) v[1:0] = k[1:0];
      wr(v);
      rd(`RCC_ADDR_HI, r);
      chk(r, v & `RCC_WRITE_MASK);
      chk(recording_mode, v[1:0]);
      chk(velocity_select, v[5]);
      chk(window_select, v[13:12]);
      if (v[1:0] != 2'h3) begin
        chk(z_is_magnitude, v[4]);
        chk(sram_hold, v[3:2] == 2'h0 || v[3:2] == 2'h3);
      end
      if (v[1:0] == 2'h2) chk(statistics_enable, v[6]);
    end
    $display("test fields done");
    for (k = 0; k < 5; k++) cap_set(masks[k], stores[k]);
    do_reset();
    wr(16'h1180);
    fire(capture_request, capture_start, hit);
    fire(capture_done, sleeping, hit);
    chk(hit, 1'b1);
    i_host.wake();
    chk(sleeping, 1'b0);
    wr(16'h1181);
    fire(auto_timer_tick, capture_start, hit);
    chk(hit, 1'b1);
    fire(capture_done, sleeping, hit);
    chk(hit, 1'b1);
    fire(auto_timer_tick, capture_start, hit);
    chk(hit, 1'b1);
    $display("test sleep done");
    do_reset();
    wr(16'h8003);
    streaming_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk(streaming_active, 1'b1);
    // Serial clocks mid-run must restart the idle count
    for (k = 1; k <= 7; k++) begin
      if (k == 4) i_host.xfer(16'h0000, r);
      fire(data_ready, stream_timed_out, hit);
    end
    chk(streaming_active, 1'b1);
    fire(data_ready, stream_timed_out, hit);
    chk(streaming_active, 1'b0);
    chk(stream_timed_out, 1'b1);
    streaming_pin = 1'b0;
    repeat (6) @(negedge clk);
    chk(stream_timed_out, 1'b0);
    wr(16'h0003);
    streaming_pin = 1'b1;
    for (k = 0; k < 9; k++) fire(data_ready, stream_timed_out, hit);
    chk(streaming_active, 1'b1);
    streaming_pin = 1'b0;
    repeat (6) @(negedge clk);
    chk(streaming_active, 1'b0);
    $display("test streaming done");
    end_sim();
  end
endmodule : recording_control_config_tb_top
